// File: hdl/aoc_consts.svh
/*
 * offsets, field positions, reset values and sizes of the alarm output
 * and compare block.
 * assumes byte addresses on a 32-bit AXI4-Lite bus, low 8 bits decoded.
 */
`ifndef AOC_CONSTS_SVH
`define AOC_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define AOC_CTRL        8'h00
`define AOC_CMD         8'h04
`define AOC_STATUS      8'h08
`define AOC_POP         8'h0c
`define AOC_POP_READING 8'h10
`define AOC_POP_STAMP   8'h14
`define AOC_PORT0_CFG   8'h18
`define AOC_PORT1_CFG   8'h1c
`define AOC_TOT_LIMIT   8'h20
`define AOC_TOT_CFG     8'h24
`define AOC_MEM_BASE    8'h40
`define AOC_MEM_TOP     8'h5c

// ****************************************
// field positions
// ****************************************
`define AOC_CTRL_LATCH  0
`define AOC_CTRL_RISE   1
`define AOC_CMD_CLR_ALL 4
`define AOC_CMD_SCAN    5
`define AOC_CMD_FRESET  6
`define AOC_CMD_STOP    7
`define AOC_PC_CARE     8
`define AOC_PC_MISM     16
`define AOC_PC_CHG      17
`define AOC_PC_EN       18
`define AOC_PC_NUM      20
`define AOC_TC_EN       0
`define AOC_TC_NUM      4

// ****************************************
// reset values and sizes
// ****************************************
`define AOC_CTRL_RST    2'b01
`define AOC_Q_DEPTH     5'd20
`define AOC_MEM_DEPTH   4'd8
`define AOC_RESP_OKAY   2'b00
`define AOC_RESP_SLVERR 2'b10

`endif

// File: hdl/aoc_pkg.sv
/*
 * types of the alarm output and compare block.
 * assumes aoc_consts.svh is included by the design file.
 */
package aoc_pkg;
  // limit-crossed code of a record
  typedef enum logic [1:0] {
    AOC_NONE = 2'b00,
    AOC_LO   = 2'b01,
    AOC_HI   = 2'b10
  } aoc_code_e;

  // one alarm event record
  typedef struct packed {
    logic [31:0] reading;
    logic [31:0] stamp;
    logic [3:0]  chan;
    aoc_code_e   code;
    logic [2:0]  num;
  } aoc_rec_s;
endpackage

// File: hdl/aoc_alarm_core.sv
/*
 * alarm output and compare core: alarm queue, output lines, digital port
 * pattern compare, totalizer count limit and a small alarm data memory.
 * assumes the scan engine and totalizer counter run on aclk and deliver
 * crossing events and counts synchronously; port pins are asynchronous.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "aoc_consts.svh"

// Operation
// - a pop returns the oldest queued event and removes it
// - popping an empty queue returns zero in every field
// - limit code: 0 no alarm, 1 low, 2 high
// - record holds reading, date-time, channel and alarm number 1 to 4
// - reading alarm memory leaves its contents unchanged
// - four lines, each the OR of channels on its alarm number
// - one mode setting for all lines; indicators follow it
// - factory reset drops all lines, queue is kept
// - hold mode: line stays set until scan start, power or clear
// - manual clear of one or all lines anytime, memory untouched
// - follow mode: line set only while condition is out of limit
// - scan start drops lines and clears alarm memory
// - falling polarity drives active lines low, rising drives high
// - factory reset returns polarity to falling
// - polarity change re-drives lines at once
// - port and totalizer alarms need no scan membership
// - port and totalizer alarms always queued, memory only in scan
// - scan start does not remove queued events
// - compare (port xor reference) and care; match zero, mismatch nonzero
// - care bit zero ignores that bit
// - compare against pattern or detect change of selected bits
// - totalizer alarm at count reaching limit, only when enabled
// - port compare inactive until enabled
// - queue an event only at the crossing moment
// - queue keeps first twenty events, later ones dropped
module aoc_alarm_core
  import aoc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog crossing events from the scan engine
  input  wire logic        ev_valid,
  input  wire logic [3:0]  ev_chan,
  input  wire logic [1:0]  ev_code,
  input  wire logic [1:0]  ev_num,
  input  wire logic [31:0] ev_reading,
  input  wire logic [31:0] time_stamp,
  // multifunction channels
  input  wire logic [7:0]  low_byte_port,
  input  wire logic [7:0]  high_byte_port,
  input  wire logic [25:0] pulse_count_channel,
  // alarm pins and front-panel indicators
  output logic [3:0]       alarm_out,
  output logic [3:0]       alarm_lamp
);

  // ****************************************
  // functions
  // ****************************************
  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // masked compare of one port against reference or last value
  function automatic logic cmp_hit(input logic [7:0] port,
      input logic [7:0] prev, input logic [31:0] cfg);
    logic [7:0] diff;
    diff = (port ^ (cfg[`AOC_PC_CHG] ? prev : cfg[7:0]))
         & cfg[`AOC_PC_CARE +: 8];
    if (!cfg[`AOC_PC_EN]) return 1'b0;
    if (cfg[`AOC_PC_CHG] || cfg[`AOC_PC_MISM])
      return |diff;
    return ~|diff;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [1:0]  ctrl;
  logic [31:0] pcfg0, pcfg1, tot_cfg;
  logic [25:0] tot_limit;
  logic        scanning;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_got, w_got;
  logic [7:0]  p0_s1, p0_s2, p1_s1, p1_s2, p0_prev, p1_prev;
  logic [2:0]  hit_q, pend;
  logic [15:0] outlim;
  logic [1:0]  onum [16];
  aoc_rec_s    queue [20];
  logic [4:0]  q_head, q_cnt;
  aoc_rec_s    mem [8];
  logic [3:0]  mem_cnt;
  aoc_rec_s    pop_rec;
  logic [3:0]  act;

  // ****************************************
  // bus decode
  // ****************************************
  wire do_wr = aw_got & w_got & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire cmd_wr = do_wr & (aw_addr == `AOC_CMD) & w_strb[0];
  wire ctrl_wr = do_wr & (aw_addr == `AOC_CTRL) & w_strb[0];
  wire [3:0] clr_sel = cmd_wr ? w_data[3:0] : 4'h0;
  wire clr_all = cmd_wr & w_data[`AOC_CMD_CLR_ALL];
  wire scan_go = cmd_wr & w_data[`AOC_CMD_SCAN];
  wire scan_stop = cmd_wr & w_data[`AOC_CMD_STOP];
  wire freset = cmd_wr & w_data[`AOC_CMD_FRESET];
  wire pop_go = rd_go & (s_axi_araddr == `AOC_POP);
  wire q_empty = (q_cnt == 5'd0);
  wire [2:0] mem_idx = s_axi_araddr[4:2];

  // write address validity, read word and read validity
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] rd_word;
  always_comb begin
    wr_ok = 1'b1;
    if (aw_addr == `AOC_CTRL) wr_ok = 1'b1;
    else if (aw_addr == `AOC_CMD) wr_ok = 1'b1;
    else if (aw_addr == `AOC_PORT0_CFG) wr_ok = 1'b1;
    else if (aw_addr == `AOC_PORT1_CFG) wr_ok = 1'b1;
    else if (aw_addr == `AOC_TOT_LIMIT) wr_ok = 1'b1;
    else if (aw_addr == `AOC_TOT_CFG) wr_ok = 1'b1;
    else wr_ok = 1'b0;
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0;
    if (s_axi_araddr == `AOC_CTRL) rd_word = {30'h0, ctrl};
    else if (s_axi_araddr == `AOC_CMD) rd_word = 32'h0;
    else if (s_axi_araddr == `AOC_STATUS)
      rd_word = {11'h0, 1'b0, mem_cnt, 3'h0, scanning, act, 3'h0, q_cnt};
    else if (s_axi_araddr == `AOC_POP)
      rd_word = q_empty ? 32'h0 : {23'h0, queue[q_head].chan,
                queue[q_head].code, queue[q_head].num};
    else if (s_axi_araddr == `AOC_POP_READING) rd_word = pop_rec.reading;
    else if (s_axi_araddr == `AOC_POP_STAMP) rd_word = pop_rec.stamp;
    else if (s_axi_araddr == `AOC_PORT0_CFG) rd_word = pcfg0;
    else if (s_axi_araddr == `AOC_PORT1_CFG) rd_word = pcfg1;
    else if (s_axi_araddr == `AOC_TOT_LIMIT) rd_word = {6'h0, tot_limit};
    else if (s_axi_araddr == `AOC_TOT_CFG) rd_word = tot_cfg;
    else if (s_axi_araddr >= `AOC_MEM_BASE &&
             s_axi_araddr <= `AOC_MEM_TOP && s_axi_araddr[1:0] == 2'b00)
      // plain read, memory is never disturbed by it
      rd_word = ({1'b0, mem_idx} < mem_cnt) ? {mem[mem_idx].reading[15:0],
                7'h0, mem[mem_idx].chan, mem[mem_idx].code,
                mem[mem_idx].num} : 32'h0;
    else rd_ok = 1'b0;
  end

  // ****************************************
  // alarm condition evaluation
  // ****************************************
  // compares run every cycle on synchronised pins
  wire hit0 = cmp_hit(p0_s2, p0_prev, pcfg0);
  wire hit1 = cmp_hit(p1_s2, p1_prev, pcfg1);
  wire hitt = tot_cfg[`AOC_TC_EN] &
              (pulse_count_channel >= tot_limit);
  wire [2:0] hit = {hitt, hit1, hit0};
  wire [2:0] rise = hit & ~hit_q;
  wire ev_cross = ev_valid & (ev_code != 2'b00);
  wire [1:0] num0 = pcfg0[`AOC_PC_NUM +: 2];
  wire [1:0] num1 = pcfg1[`AOC_PC_NUM +: 2];
  wire [1:0] numt = tot_cfg[`AOC_TC_NUM +: 2];

  // per-line OR of every source assigned to it
  logic [3:0] cond, act_set;
  always_comb begin
    cond = 4'h0;
    act_set = 4'h0;
    for (int c = 0; c < 16; c++) begin
      if (outlim[c]) cond[onum[c]] = 1'b1;
    end
    if (hit0) cond[num0] = 1'b1;
    if (hit1) cond[num1] = 1'b1;
    if (hitt) cond[numt] = 1'b1;
    if (ev_cross) act_set[ev_num] = 1'b1;
    if (rise[0]) act_set[num0] = 1'b1;
    if (rise[1]) act_set[num1] = 1'b1;
    if (rise[2]) act_set[numt] = 1'b1;
  end

  // one event enters the queue per cycle; scan events have priority
  wire [2:0] srv = ev_cross ? 3'b000 : (pend[0] ? 3'b001 :
                   (pend[1] ? 3'b010 : (pend[2] ? 3'b100 : 3'b000)));
  wire push = ev_cross | (|pend);
  aoc_rec_s new_rec;
  always_comb begin
    new_rec.reading = 32'h0;
    new_rec.stamp = time_stamp;
    new_rec.code = AOC_HI;
    new_rec.chan = 4'h0;
    new_rec.num = 3'd0;
    if (ev_cross) begin
      new_rec.reading = ev_reading;
      new_rec.chan = ev_chan;
      new_rec.code = aoc_code_e'(ev_code);
      new_rec.num = {1'b0, ev_num} + 3'd1;
    end else if (srv[0]) begin
      new_rec.reading = {24'h0, p0_s2};
      new_rec.num = {1'b0, num0} + 3'd1;
    end else if (srv[1]) begin
      new_rec.reading = {24'h0, p1_s2};
      new_rec.chan = 4'h1;
      new_rec.num = {1'b0, num1} + 3'd1;
    end else begin
      new_rec.reading = {6'h0, pulse_count_channel};
      new_rec.chan = 4'h2;
      new_rec.num = {1'b0, numt} + 3'd1;
    end
  end

  // line state: hold mode keeps it, follow mode needs the condition
  wire line_clr = clr_all | scan_go | freset;
  wire [3:0] keep = ctrl[`AOC_CTRL_LATCH] ? 4'hf :
                    (cond | act_set);
  wire [3:0] next_act = (act & keep & ~clr_sel & ~{4{line_clr}}) |
                        act_set;  // new alarm beats a clear
  wire next_rise = freset ? 1'b0 :
                   (ctrl_wr ? w_data[`AOC_CTRL_RISE] : ctrl[`AOC_CTRL_RISE]);
  wire [5:0] q_sum = {1'b0, q_head} + {1'b0, q_cnt};
  wire [4:0] q_tail = (q_sum >= 6'd20) ? 5'(q_sum - 6'd20) : q_sum[4:0];

  // ****************************************
  // axi handshake
  // ****************************************
  // one write and one read in flight, address and data in any order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AOC_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `AOC_RESP_OKAY : `AOC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AOC_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `AOC_RESP_OKAY : `AOC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // one mode and one polarity shared by all four lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `AOC_CTRL_RST;
      pcfg0 <= 32'h0;
      pcfg1 <= 32'h0;
      tot_cfg <= 32'h0;
      tot_limit <= 26'h0;
      scanning <= 1'b0;
    end else if (ce) begin
      ctrl[`AOC_CTRL_RISE] <= next_rise;
      if (ctrl_wr) ctrl <= w_data[1:0];
      if (do_wr && aw_addr == `AOC_PORT0_CFG)
        pcfg0 <= wmerge(pcfg0, w_data, w_strb);
      if (do_wr && aw_addr == `AOC_PORT1_CFG)
        pcfg1 <= wmerge(pcfg1, w_data, w_strb);
      if (do_wr && aw_addr == `AOC_TOT_CFG)
        tot_cfg <= wmerge(tot_cfg, w_data, w_strb);
      if (do_wr && aw_addr == `AOC_TOT_LIMIT)
        tot_limit <= 26'(wmerge({6'h0, tot_limit}, w_data, w_strb));
      if (scan_go) scanning <= 1'b1;
      else if (scan_stop) scanning <= 1'b0;
    end
  end

  // ****************************************
  // input sampling and edge memory
  // ****************************************
  // two flops on the port pins; change mode compares the second with its value one cycle earlier
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p0_s1 <= 8'h0;
      p0_s2 <= 8'h0;
      p1_s1 <= 8'h0;
      p1_s2 <= 8'h0;
      p0_prev <= 8'h0;
      p1_prev <= 8'h0;
      hit_q <= 3'h0;
      pend <= 3'h0;
    end else if (ce) begin
      p0_s1 <= low_byte_port;
      p0_s2 <= p0_s1;
      p1_s1 <= high_byte_port;
      p1_s2 <= p1_s1;
      p0_prev <= p0_s2;
      p1_prev <= p1_s2;
      hit_q <= hit;
      // new crossing wins over service in the same cycle
      pend <= (pend & ~srv) | rise;
    end
  end

  // analog out-of-limit map, updated by crossing and return events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outlim <= 16'h0;
      for (int c = 0; c < 16; c++) onum[c] <= 2'd0;
    end else if (ce && ev_valid) begin
      outlim[ev_chan] <= (ev_code != 2'b00);
      onum[ev_chan] <= ev_num;
    end
  end

  // ****************************************
  // alarm queue and alarm memory
  // ****************************************
  // full queue drops new events; scan start leaves it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_head <= 5'd0;
      q_cnt <= 5'd0;
      pop_rec <= '0;
    end else if (ce) begin
      if (push && q_cnt < `AOC_Q_DEPTH) queue[q_tail] <= new_rec;
      if (pop_go) begin
        pop_rec <= q_empty ? '0 : queue[q_head];
        if (!q_empty)
          q_head <= (q_head == 5'd19) ? 5'd0 : q_head + 5'd1;
      end
      if (push && q_cnt < `AOC_Q_DEPTH && !(pop_go && !q_empty))
        q_cnt <= q_cnt + 5'd1;
      else if (!(push && q_cnt < `AOC_Q_DEPTH) && pop_go && !q_empty)
        q_cnt <= q_cnt - 5'd1;
    end
  end

  // alarm data recorded only while scanning, dropped at scan start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_cnt <= 4'd0;
    end else if (ce) begin
      if (scan_go) mem_cnt <= 4'd0;
      else if (push && scanning && mem_cnt < `AOC_MEM_DEPTH) begin
        mem[mem_cnt[2:0]] <= new_rec;
        mem_cnt <= mem_cnt + 4'd1;
      end
    end
  end

  // ****************************************
  // output lines
  // ****************************************
  // pins use the next polarity so a change shows at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act <= 4'h0;
      alarm_out <= 4'hf;
      alarm_lamp <= 4'h0;
    end else if (ce) begin
      act <= next_act;
      alarm_out <= next_rise ? next_act : ~next_act;
      alarm_lamp <= next_act;
    end
  end

endmodule

// File: test/aoc_alarm_core_assertions.sv
/*
 * port checker for the alarm output and compare core.
 * assumes one aclk domain and a synchronous active-low aresetn.
 */
// ****************************************
// checker
// ****************************************
module aoc_alarm_core_chk (
  // clock and control
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // events and lines
  input wire logic        ev_valid,
  input wire logic [1:0]  ev_code,
  input wire logic [1:0]  ev_num,
  input wire logic [3:0]  alarm_out,
  input wire logic [3:0]  alarm_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // write taken on both channels, then the two-step answer
  sequence s_wr_take;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  property p_wr_answer;
    s_wr_take |=> s_wr_answer;
  endproperty
  property p_rd_answer;
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  // a crossing sets its line, even against a clear on that edge
  property p_ev_line;
    ce && ev_valid && ev_code != 2'b00
      |=> alarm_lamp[$past(ev_num)];
  endproperty
  // one polarity for all four pins
  property p_shared_pol;
    alarm_out == ~alarm_lamp || alarm_out == alarm_lamp;
  endproperty
  // pins moving with no change of lamps means a polarity flip of all four
  property p_pol_redrive;
    $changed(alarm_out) && $stable(alarm_lamp)
      |-> alarm_out == ~$past(alarm_out);
  endproperty
  property p_ce_freeze;
    !ce |=> $stable(alarm_out) && $stable(alarm_lamp);
  endproperty

  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer timing wrong");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer timing wrong");
  a_b_stands: assert property (p_b_stands)
    else $error("write response dropped early");
  a_r_stands: assert property (p_r_stands)
    else $error("read data changed while waiting");
  a_ev_line: assert property (p_ev_line)
    else $error("crossing did not set its line");
  a_shared_pol: assert property (p_shared_pol)
    else $error("pins disagree on polarity");
  a_pol_redrive: assert property (p_pol_redrive)
    else $error("pins changed without a cause");
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("lines moved while frozen");
endmodule

// File: test/aoc_lights.sv
/*
 * external indicator model: lamps driven by the alarm pins.
 * assumes the bench tells it which pin level means alarm.
 */
// ****************************************
// indicator model
// ****************************************
module aoc_lights (
  // pins and wiring choice
  input  wire logic [3:0] alarm_out,
  input  wire logic       pol_rise,
  // lamp state seen by an operator
  output logic [3:0]      lit
);
  timeunit 1ns;
  timeprecision 1ps;
  // the indicator only knows the pin level, not the core state
  assign lit = pol_rise ? alarm_out : ~alarm_out;
endmodule

// File: test/tb_alarm_output_compare.sv
/*
 * self-checking bench of the alarm output and compare core.
 * assumes aoc_consts.svh on the include path and a 40 MHz aclk.
 */
`include "aoc_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

// ****************************************
// bench top
// ****************************************
module tb_alarm_output_compare
  import aoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, ce = 1, pol_rise = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, ev_reading = '0;
  logic [3:0]  s_axi_wstrb = 4'hf, ev_chan = '0, alarm_out, alarm_lamp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, ev_valid = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ev_code = '0, ev_num = '0;
  logic [31:0] time_stamp = '0, rdat, keep;
  logic [7:0]  low_byte_port = '0, high_byte_port = '0;
  logic [25:0] pulse_count_channel = '0;
  logic [3:0]  lit;
  int          err_count = 0, n_checks = 0, cyc = 0, qn = 0;

  aoc_alarm_core dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ev_valid, .ev_chan, .ev_code, .ev_num,
    .ev_reading, .time_stamp, .low_byte_port, .high_byte_port,
    .pulse_count_channel, .alarm_out, .alarm_lamp);
  aoc_lights lights_u (.alarm_out, .pol_rise, .lit);

  // clock, running time stamp and hang guard
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    time_stamp <= time_stamp + 32'h1;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // bus write: response taken as soon as it is offered
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rdat = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // one crossing pulse; returns once the lines show its effect
  task automatic ev(input logic [3:0] c, input logic [1:0] k, n);
    @(posedge aclk);
    ev_chan    <= c;
    ev_code    <= k;
    ev_num     <= n;
    ev_reading <= 32'h1000 + c;
    ev_valid   <= 1'b1;
    @(posedge aclk);
    ev_valid   <= 1'b0;
    @(posedge aclk);
    if (k != 2'b00 && qn < 20) qn++;
  endtask

  function automatic logic [31:0] pw(input logic [3:0] c,
                                     input logic [1:0] k, input logic [2:0] n);
    return {23'h0, c, k, n};
  endfunction

  task automatic t_reset();
    `CHK(alarm_out, 4'hf)
    rd(`AOC_CTRL);
    `CHK(rdat, 32'h1)
    rd(`AOC_POP);
    `CHK(rdat, 32'h0)
    rd(`AOC_POP_READING);
    `CHK(rdat, 32'h0)
    rd(8'h30);
    `CHK(s_axi_rresp, 2'b10)
    wr(8'h30, 32'h1);
    `CHK(s_axi_bresp, 2'b10)
  endtask

  task automatic t_queue();
    ev(4'd3, AOC_HI, 2'd1);
    `CHK(alarm_lamp, 4'b0010)
    `CHK(alarm_out, 4'b1101)
    ev(4'd5, AOC_LO, 2'd1);
    ev(4'd5, AOC_NONE, 2'd1);
    `CHK(alarm_lamp, 4'b0010)
    rd(`AOC_STATUS);
    `CHK(rdat[4:0], 5'd2)
    rd(`AOC_POP);
    `CHK(rdat, pw(4'd3, 2'd2, 3'd2))
    rd(`AOC_POP_READING);
    `CHK(rdat, 32'h1003)
    rd(`AOC_POP);
    `CHK(rdat, pw(4'd5, 2'd1, 3'd2))
    qn = 0;
  endtask

  task automatic t_clear_pol();
    wr(`AOC_CMD, 32'h2);
    `CHK(alarm_lamp, 4'h0)
    ev(4'd0, AOC_HI, 2'd2);
    ev(4'd1, AOC_HI, 2'd3);
    wr(`AOC_CMD, 32'h10);
    `CHK(alarm_lamp, 4'h0)
    ev(4'd2, AOC_HI, 2'd0);
    pol_rise <= 1'b1;
    wr(`AOC_CTRL, 32'h3);
    `CHK(alarm_out, 4'b0001)
    `CHK(lit, 4'b0001)
    pol_rise <= 1'b0;
    wr(`AOC_CTRL, 32'h1);
    `CHK(alarm_out, 4'b1110)
  endtask

  task automatic t_follow_freset();
    wr(`AOC_CMD, 32'h10);
    wr(`AOC_CTRL, 32'h0);
    ev(4'd4, AOC_HI, 2'd3);
    `CHK(alarm_lamp, 4'b1000)
    ev(4'd1, AOC_NONE, 2'd3);
    ev(4'd4, AOC_NONE, 2'd3);
    @(posedge aclk);
    `CHK(alarm_lamp, 4'b0000)
    wr(`AOC_CTRL, 32'h3);
    ev(4'd6, AOC_LO, 2'd2);
    wr(`AOC_CMD, 32'h40);
    `CHK(alarm_out, 4'hf)
    rd(`AOC_CTRL);
    `CHK(rdat, 32'h1)
    rd(`AOC_STATUS);
    `CHK(rdat[4:0], qn[4:0])
  endtask

  task automatic t_full();
    repeat (qn) rd(`AOC_POP);
    qn = 0;
    for (int i = 0; i < 22; i++) ev(i[3:0], AOC_HI, 2'd0);
    rd(`AOC_STATUS);
    `CHK(rdat[4:0], 5'd20)
    rd(`AOC_POP);
    `CHK(rdat, pw(4'd0, 2'd2, 3'd1))
    repeat (19) rd(`AOC_POP);
    `CHK(rdat, pw(4'd3, 2'd2, 3'd1))
    qn = 0;
  endtask

  // scan start, then port compare while scanning
  task automatic t_scan_port();
    ev(4'd7, AOC_HI, 2'd1);
    wr(`AOC_CMD, 32'h20);
    `CHK(alarm_lamp, 4'h0)
    rd(`AOC_STATUS);
    `CHK(rdat[16:0], {4'h0, 1'b1, 7'h0, 5'd1})
    low_byte_port <= 8'h80;
    wr(`AOC_PORT0_CFG, 32'h0020f080);
    repeat (6) @(posedge aclk);
    `CHK(alarm_lamp, 4'h0)
    low_byte_port <= 8'h92;
    wr(`AOC_PORT0_CFG, 32'h0024f080);
    repeat (6) @(posedge aclk);
    `CHK(alarm_lamp, 4'h0)
    low_byte_port <= 8'h8f;
    repeat (6) @(posedge aclk);
    `CHK(alarm_lamp, 4'b0100)
    rd(`AOC_MEM_BASE);
    `CHK(rdat, 32'h008f0013)
    keep = rdat;
    rd(`AOC_MEM_BASE);
    `CHK(rdat, keep)
    wr(`AOC_CMD, 32'h10);
    wr(`AOC_PORT0_CFG, 32'h0025f080);
    low_byte_port <= 8'h9f;
    repeat (6) @(posedge aclk);
    `CHK(alarm_lamp, 4'b0100)
    wr(`AOC_CMD, 32'h10);
    wr(`AOC_PORT0_CFG, 32'h0026f080);
    low_byte_port <= 8'h8f;
    repeat (6) @(posedge aclk);
    `CHK(alarm_lamp, 4'b0100)
  endtask

  task automatic t_total();
    wr(`AOC_CMD, 32'h90);
    pulse_count_channel <= 26'd100;
    wr(`AOC_TOT_LIMIT, 32'd100);
    wr(`AOC_TOT_CFG, 32'h10);
    repeat (4) @(posedge aclk);
    `CHK(alarm_lamp, 4'h0)
    wr(`AOC_TOT_CFG, 32'h11);
    repeat (4) @(posedge aclk);
    `CHK(alarm_lamp, 4'b0010)
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    `CHK(alarm_lamp, 4'b0010)
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_queue();
    t_clear_pol();
    t_follow_freset();
    t_full();
    t_scan_port();
    t_total();
    report_and_stop();
  end
endmodule

bind aoc_alarm_core aoc_alarm_core_chk chk_u (.aclk, .aresetn, .ce,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .ev_valid, .ev_code, .ev_num, .alarm_out, .alarm_lamp);
